// ==== cpu_decode_regs.svh ====
// constants for the processor address decode and bus steering block
// assumes a 200 MHz system clock and an 8 MHz processor bus
//
// Summary of operation
// - bus timing counted in 125 ns T states
// - address captured at strobe fall, held through cycle
// - upper address and status latched with address
// - direction high on writes, set in first state
// - buffer enable asserts only once data present
// - status bits separate memory, peripheral, read, write
// - low select unused; mid selects 0-3 decode
// - mid select 3 and boot select regions
// - seven 128-byte peripheral select windows
// - mid areas zero waits, honour external ready
// - boot area three waits, ignores ready
// - peripheral areas two waits, ignore ready
// - peripheral 0 split into eight 16-byte selects
// - 16-byte selects qualified by select and strobe
// - first block split into mirrored 2-byte selects
// - 2-byte selects serve mux, count, unused
// - four 32-byte DMA acknowledges from 0080H
// - acknowledge 0 floppy, 3 disk, 1-3 external
// - steering high for local, low for external
// - local targets listed, all others external
// - 100 us timeout forces ready and local
// - boot select or interrupt ack drive sync ready
`ifndef CPU_DECODE_REGS_SVH
`define CPU_DECODE_REGS_SVH

`define CLK_PERIOD_NS 5
`define T_STATE_NS 125
`define T_STATE_CYC ((`T_STATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_US 100
`define TIMEOUT_CYC (`TIMEOUT_US * 1000 / `CLK_PERIOD_NS)

`define STAT_INTA 3'h0
`define STAT_IO_RD 3'h1
`define STAT_IO_WR 3'h2
`define STAT_FETCH 3'h4
`define STAT_MEM_RD 3'h5
`define STAT_MEM_WR 3'h6
`define STAT_PASSIVE 3'h7

`define NUM_MID 4
`define MID_MASK 20'he0000
`define MID_STEP 20'h20000
`define BOOT_BASE 20'hf8000
`define BOOT_MASK 20'hf8000
`define NUM_PERIPH 7
`define PERIPH_MASK 20'h0ff80
`define PERIPH_STEP 20'h00080
`define NUM_DEV16 8
`define DEV16_MASK 20'h0fff0
`define DEV16_STEP 20'h00010
`define NUM_DEV2 4
`define DEV2_MASK 20'h0fff6
`define DEV2_STEP 20'h00002
`define NUM_DMA 4
`define DMA_BASE 20'h00080
`define DMA_MASK 20'h0ffe0
`define DMA_STEP 20'h00020

`define WAIT_MID 3'h0
`define WAIT_PERIPH 3'h2
`define WAIT_BOOT 3'h3
`define WAIT_ONE 3'h1
`define TDIV_ZERO 5'h00
`define TDIV_ONE 5'h01
`define TO_ZERO 16'h0000
`define TO_ONE 16'h0001

`endif

// ==== cpu_decode_pkg.sv ====
// types shared by the address decode and bus steering block
// assumes nothing beyond a SystemVerilog elaborator
package cpu_decode_pkg;
   typedef logic [2:0] status_t;
   typedef enum logic [2:0] {
      CYC_IDLE = 3'b001,
      CYC_ADDR = 3'b010,
      CYC_DATA = 3'b100
   } cyc_state_t;
   typedef struct packed {
      logic async_ready;
      logic hold;
      logic ale;
      status_t st;
      logic [3:0] hi;
      logic [15:0] ad;
   } pin_in_t;
endpackage

// ==== decode_if.sv ====
// latched address and cycle kind passed to the window decoders
// assumes one driver, the bus steering module
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
   logic [19:0] addr;
   logic mem_cyc;
   logic io_cyc;
   logic qual;
   modport src (output addr, output mem_cyc, output io_cyc, output qual);
   modport dec (input addr, input mem_cyc, input io_cyc, input qual);
endinterface
`default_nettype wire

// ==== addr_window.sv ====
// one address window decoder with an active-low select
// assumes the latched address is stable while qual is high
`timescale 1ns/1ps
`default_nettype none
module addr_window #(
   parameter logic [19:0] BASE = 20'h00000,
   parameter logic [19:0] MASK = 20'hfffff,
   parameter bit IS_MEM = 1'b1
) (
   decode_if.dec bus,
   input wire logic en_i,
   output logic hit_n_o
);
   wire logic space_ok;
   wire logic match;
   // only the own address space answers
   assign space_ok = IS_MEM ? bus.mem_cyc : bus.io_cyc;
   assign match = ((bus.addr ^ BASE) & MASK) == 20'h00000;
   // combinational, quiet while the strobe is high
   assign hit_n_o = ~(en_i & bus.qual & space_ok & match);
endmodule
`default_nettype wire

// ==== cpu_bus_steer.sv ====
// address latch, chip select decode, waits and bus steering
// assumes processor pins arrive asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.svh"
module cpu_bus_steer #(
   parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [15:0] addr_data_i,
   input wire logic [3:0] addr_hi_i,
   input wire cpu_decode_pkg::status_t proc_status_bits_i,
   input wire logic addr_latch_strobe_i,
   input wire logic hold_granted_i,
   input wire logic async_ready_i,
   output logic [19:0] latched_addr_o,
   output cpu_decode_pkg::status_t latched_status_o,
   output logic data_dir_tx_rx_o,
   output logic data_buf_en_n_o,
   output logic low_mem_sel_n_o,
   output logic [3:0] mid_mem_sel_n_o,
   output logic boot_mem_sel_n_o,
   output logic [6:0] periph_sel_n_o,
   output logic [7:0] dev16_sel_n_o,
   output logic [3:0] dev2_sel_n_o,
   output logic [3:0] dma_ack_n_o,
   output logic int_ack_n_o,
   output logic local_not_external_o,
   output logic sync_ready_o,
   output logic cycle_ready_o,
   output logic bus_timeout_n_o
);
   import cpu_decode_pkg::*;

   pin_in_t pin_raw;
   pin_in_t pin_s1_reg;
   pin_in_t pin_s2_reg;
   logic ale_d_reg;
   logic [4:0] tdiv_reg;
   logic [4:0] tdiv_next;
   cyc_state_t state_reg;
   cyc_state_t state_next;
   logic [19:0] addr_reg;
   status_t status_reg;
   logic dir_reg;
   logic den_reg;
   logic den_next;
   logic [2:0] wait_reg;
   logic [2:0] wait_next;
   logic [15:0] to_cnt_reg;
   logic [15:0] to_cnt_next;
   logic to_reg;
   logic to_next;

   wire logic ale_s;
   wire logic hold_s;
   wire logic async_ready_s;
   wire logic ale_rise;
   wire logic ale_fall;
   wire logic t_en;
   wire logic in_data;
   wire logic st_passive;
   wire logic wr_now;
   wire logic mem_cyc;
   wire logic io_cyc;
   wire logic inta_cyc;
   wire logic boot_hit;
   wire logic periph_any;
   wire logic honour_rdy;
   wire logic [2:0] waits_req;
   wire logic wait_ok;
   wire logic to_expire;

   // two-stage synchroniser on all processor pins
   assign pin_raw = '{async_ready: async_ready_i, hold: hold_granted_i,
                      ale: addr_latch_strobe_i, st: proc_status_bits_i,
                      hi: addr_hi_i, ad: addr_data_i};

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         ale_d_reg <= 1'b0;
      end
      else
      begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         ale_d_reg <= pin_s2_reg.ale;
      end
   end

   assign ale_s = pin_s2_reg.ale;
   assign hold_s = pin_s2_reg.hold;
   assign async_ready_s = pin_s2_reg.async_ready;
   assign ale_rise = ale_s & ~ale_d_reg;
   assign ale_fall = ~ale_s & ale_d_reg;
   assign st_passive = pin_s2_reg.st == `STAT_PASSIVE;
   assign wr_now = (pin_s2_reg.st == `STAT_MEM_WR) | (pin_s2_reg.st == `STAT_IO_WR);

   // T state enable, one pulse per 125 ns
   assign t_en = tdiv_reg == 5'(`T_STATE_CYC - 1);
   assign tdiv_next = t_en ? `TDIV_ZERO : tdiv_reg + `TDIV_ONE;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         tdiv_reg <= `TDIV_ZERO;
      else
         tdiv_reg <= tdiv_next;
   end

   // bus cycle sequencing
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         CYC_IDLE:
            if (ale_rise)
               state_next = CYC_ADDR;
         CYC_ADDR:
            if (ale_fall)
               state_next = CYC_DATA;
         CYC_DATA:
            if (ale_rise)
               state_next = CYC_ADDR;
            else if (st_passive)
               state_next = CYC_IDLE;
         default:
            state_next = CYC_IDLE;
      endcase
   end

   assign in_data = state_reg == CYC_DATA;

   // data enable once the first T state has passed
   assign den_next = (state_next == CYC_DATA) & (den_reg | (in_data & t_en));
   // wait states counted from data enable onward
   assign wait_next = ale_fall ? `WAIT_MID :
                      (den_reg & t_en & (wait_reg != `WAIT_BOOT)) ?
                      wait_reg + `WAIT_ONE : wait_reg;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= CYC_IDLE;
         den_reg <= 1'b0;
         wait_reg <= `WAIT_MID;
      end
      else
      begin
         state_reg <= state_next;
         den_reg <= den_next;
         wait_reg <= wait_next;
      end
   end

   // address, status and direction latched at strobe fall
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         addr_reg <= 20'h00000;
         status_reg <= `STAT_PASSIVE;
         dir_reg <= 1'b0;
      end
      else if (ale_fall)
      begin
         addr_reg <= {pin_s2_reg.hi, pin_s2_reg.ad};
         status_reg <= pin_s2_reg.st;
         dir_reg <= wr_now;
      end
   end

   // bus timeout restarted at strobe rise
   assign to_expire = to_cnt_reg == `TO_ONE;
   assign to_cnt_next = ale_rise ? 16'(TIMEOUT_CYCLES) :
                        (to_cnt_reg != `TO_ZERO) ? to_cnt_reg - `TO_ONE : to_cnt_reg;
   assign to_next = den_reg & (to_reg | to_expire);

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         to_cnt_reg <= `TO_ZERO;
         to_reg <= 1'b0;
      end
      else
      begin
         to_cnt_reg <= to_cnt_next;
         to_reg <= to_next;
      end
   end

   // cycle kind from latched status
   assign mem_cyc = (status_reg == `STAT_FETCH) | (status_reg == `STAT_MEM_RD) |
                    (status_reg == `STAT_MEM_WR);
   assign io_cyc = (status_reg == `STAT_IO_RD) | (status_reg == `STAT_IO_WR);
   assign inta_cyc = in_data & (status_reg == `STAT_INTA);

   decode_if dbus ();
   assign dbus.addr = addr_reg;
   assign dbus.mem_cyc = mem_cyc;
   assign dbus.io_cyc = io_cyc;
   // selects only while address stable and bus owned
   assign dbus.qual = in_data & ~ale_s & ~hold_s;

   assign low_mem_sel_n_o = 1'b1;

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_MID; gi++)
      begin : g_mid
         addr_window #(.BASE(20'(`MID_STEP * gi)), .MASK(`MID_MASK), .IS_MEM(1'b1)) u_win (
            .bus(dbus),
            .en_i(1'b1),
            .hit_n_o(mid_mem_sel_n_o[gi])
         );
      end
      for (gi = 0; gi < `NUM_PERIPH; gi++)
      begin : g_periph
         addr_window #(.BASE(20'(`PERIPH_STEP * gi)), .MASK(`PERIPH_MASK), .IS_MEM(1'b0))
         u_win (
            .bus(dbus),
            .en_i(1'b1),
            .hit_n_o(periph_sel_n_o[gi])
         );
      end
      for (gi = 0; gi < `NUM_DEV16; gi++)
      begin : g_dev16
         addr_window #(.BASE(20'(`DEV16_STEP * gi)), .MASK(`DEV16_MASK), .IS_MEM(1'b0))
         u_win (
            .bus(dbus),
            .en_i(~periph_sel_n_o[0]),
            .hit_n_o(dev16_sel_n_o[gi])
         );
      end
      for (gi = 0; gi < `NUM_DEV2; gi++)
      begin : g_dev2
         addr_window #(.BASE(20'(`DEV2_STEP * gi)), .MASK(`DEV2_MASK), .IS_MEM(1'b0))
         u_win (
            .bus(dbus),
            .en_i(~dev16_sel_n_o[0]),
            .hit_n_o(dev2_sel_n_o[gi])
         );
      end
      for (gi = 0; gi < `NUM_DMA; gi++)
      begin : g_dma
         addr_window #(.BASE(20'(`DMA_BASE + `DMA_STEP * gi)), .MASK(`DMA_MASK),
                       .IS_MEM(1'b0)) u_win (
            .bus(dbus),
            .en_i(1'b1),
            .hit_n_o(dma_ack_n_o[gi])
         );
      end
   endgenerate

   addr_window #(.BASE(`BOOT_BASE), .MASK(`BOOT_MASK), .IS_MEM(1'b1)) u_boot (
      .bus(dbus),
      .en_i(1'b1),
      .hit_n_o(boot_mem_sel_n_o)
   );

   assign boot_hit = ~boot_mem_sel_n_o;
   assign periph_any = ~&periph_sel_n_o;
   assign int_ack_n_o = ~inta_cyc;

   // per-region wait count and ready use
   assign waits_req = boot_hit ? `WAIT_BOOT :
                      periph_any ? `WAIT_PERIPH : `WAIT_MID;
   assign honour_rdy = ~(boot_hit | periph_any);
   assign wait_ok = den_reg & (wait_reg >= waits_req);
   assign cycle_ready_o = (wait_ok & (~honour_rdy | async_ready_s)) | to_reg;
   assign sync_ready_o = boot_hit | inta_cyc;

   // local versus external steering
   assign local_not_external_o = ~mid_mem_sel_n_o[0] | ~mid_mem_sel_n_o[1] |
                                 ~periph_sel_n_o[0] | boot_hit | ~dma_ack_n_o[0] |
                                 inta_cyc | to_reg;

   assign latched_addr_o = addr_reg;
   assign latched_status_o = status_reg;
   assign data_dir_tx_rx_o = dir_reg;
   assign data_buf_en_n_o = ~den_reg;
   assign bus_timeout_n_o = ~to_reg;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   AST_DIR_WRITE: assert property (ale_fall && wr_now |=> data_dir_tx_rx_o)
      else $error("direction not high after write latch");
   AST_DEN_DATA: assert property (!data_buf_en_n_o |-> state_reg == CYC_DATA)
      else $error("data enable outside data phase");
   AST_ADDR_HOLD: assert property (in_data && $past(in_data) |-> $stable(latched_addr_o))
      else $error("latched address changed mid cycle");
   AST_SEL_QUIET: assert property (ale_s |-> &dev16_sel_n_o && &mid_mem_sel_n_o)
      else $error("select active while strobe high");
   AST_BOOT_WAITS: assert property (
      cycle_ready_o && boot_hit && !to_reg |-> wait_reg == `WAIT_BOOT)
      else $error("boot cycle released early");
   AST_PERIPH_WAITS: assert property (
      cycle_ready_o && periph_any && !to_reg |-> wait_reg >= `WAIT_PERIPH)
      else $error("peripheral cycle released early");
   AST_MID_SPACE: assert property (!(&mid_mem_sel_n_o) |-> mem_cyc)
      else $error("memory select in non memory cycle");
   AST_SYNC_READY: assert property (boot_hit || !int_ack_n_o |-> sync_ready_o)
      else $error("sync ready missing");
   AST_TIMEOUT: assert property (!bus_timeout_n_o |-> local_not_external_o && cycle_ready_o)
      else $error("timeout did not force local and ready");
   AST_LOCAL_DMA0: assert property (!dma_ack_n_o[0] |-> local_not_external_o)
      else $error("dma ack 0 not local");
   AST_EXT_DMA3: assert property (!dma_ack_n_o[3] && !to_reg |-> !local_not_external_o)
      else $error("dma ack 3 not external");
   AST_T_STATE: assert property (t_en |=> !t_en [*8])
      else $error("T state enable too frequent");
   // space, nesting, hold, ready, direction, enable and steering checks
   AST_BOOT_SPACE: assert property (boot_hit |-> mem_cyc)
      else $error("boot select in non memory cycle");
   AST_IO_SPACE: assert property (!(&periph_sel_n_o) |-> io_cyc)
      else $error("peripheral select in non io cycle");
   AST_DMA_SPACE: assert property (!(&dma_ack_n_o) |-> io_cyc)
      else $error("dma ack in non io cycle");
   AST_DEV16_IN_P0: assert property (!(&dev16_sel_n_o) |-> !periph_sel_n_o[0])
      else $error("16-byte select outside peripheral 0");
   AST_DEV2_IN_D16: assert property (!(&dev2_sel_n_o) |-> !dev16_sel_n_o[0])
      else $error("2-byte select outside first block");
   AST_HOLD_QUIET: assert property (hold_s |-> &periph_sel_n_o && &dma_ack_n_o)
      else $error("select active while hold granted");
   AST_MID_READY: assert property (cycle_ready_o && honour_rdy && !to_reg |-> async_ready_s)
      else $error("ready honouring cycle released without ready");
   AST_DIR_READ: assert property (ale_fall && !wr_now |=> !data_dir_tx_rx_o)
      else $error("direction not low after read latch");
   AST_DEN_ON_TICK: assert property ($fell(data_buf_en_n_o) |-> $past(t_en))
      else $error("data enable off the T state tick");
   AST_INTA_LOCAL: assert property (!int_ack_n_o |-> local_not_external_o)
      else $error("interrupt ack not local");
   AST_BOOT_LOCAL: assert property (boot_hit |-> local_not_external_o)
      else $error("boot select not local");
   AST_IDLE_QUIET: assert property (!in_data |-> data_buf_en_n_o && &periph_sel_n_o)
      else $error("enable or select outside data phase");
endmodule
`default_nettype wire

// ==== cpu_core_model.sv ====
// processor core model issuing multiplexed address-data cycles
// assumes ready_i is the block's cycle release
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.svh"
module cpu_core_model (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic [15:0] ad_o,
   output logic [3:0] hi_o,
   output cpu_decode_pkg::status_t st_o,
   output logic ale_o
);
   import cpu_decode_pkg::*;
   initial
   begin
      ad_o = 16'h0000;
      hi_o = 4'h0;
      st_o = `STAT_PASSIVE;
      ale_o = 1'h0;
   end
   // address phase, then data phase until ready is seen at an edge
   task automatic bus_cycle(input logic [19:0] a, input status_t st);
      int n;
      @(posedge clk_i);
      #1;
      {hi_o, ad_o} = a;
      st_o = st;
      ale_o = 1'h1;
      repeat (6) @(posedge clk_i);
      #1;
      ale_o = 1'h0;
      repeat (4) @(posedge clk_i);
      #1;
      ad_o = ~a[15:0];
      n = 0;
      while (ready_i !== 1'h1 && n < 1000)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      @(posedge clk_i);
      #1;
      st_o = `STAT_PASSIVE;
      {hi_o, ad_o} = ~a;
      repeat (6) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// bench for the bus steering block: decode, waits, steering, timeout
// assumes the core model drives the processor pins
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAIT_UNTIL(c) begin n = 0; while (!(c) && n < 300) begin @(posedge clk_sys_i); #2; n++; end \
   if (!(c)) begin fails++; $display("[ERR] wait_until exp 1 got 0"); end end
module tb;
   import cpu_decode_pkg::*;
   localparam int TO_CYC = 200;
   logic clk_sys_i, arst_n_i, hold_granted_i, async_ready_i, addr_latch_strobe_i;
   logic [15:0] addr_data_i;
   logic [3:0] addr_hi_i, mid_mem_sel_n_o, dev2_sel_n_o, dma_ack_n_o;
   status_t proc_status_bits_i, latched_status_o;
   logic [19:0] latched_addr_o;
   logic data_dir_tx_rx_o, data_buf_en_n_o, low_mem_sel_n_o, boot_mem_sel_n_o, int_ack_n_o;
   logic local_not_external_o, sync_ready_o, cycle_ready_o, bus_timeout_n_o;
   logic [6:0] periph_sel_n_o;
   logic [7:0] dev16_sel_n_o;
   logic [30:0] sel_seen;
   int fails, n_checks, cyc;
   assign sel_seen = {mid_mem_sel_n_o, boot_mem_sel_n_o, periph_sel_n_o, dev16_sel_n_o,
      dev2_sel_n_o, dma_ack_n_o, int_ack_n_o, local_not_external_o, sync_ready_o};
   cpu_bus_steer #(.TIMEOUT_CYCLES(TO_CYC)) uut (.clk_sys_i, .arst_n_i, .addr_data_i,
      .addr_hi_i, .proc_status_bits_i, .addr_latch_strobe_i, .hold_granted_i, .async_ready_i,
      .latched_addr_o, .latched_status_o, .data_dir_tx_rx_o, .data_buf_en_n_o, .low_mem_sel_n_o,
      .mid_mem_sel_n_o, .boot_mem_sel_n_o, .periph_sel_n_o, .dev16_sel_n_o, .dev2_sel_n_o,
      .dma_ack_n_o, .int_ack_n_o, .local_not_external_o, .sync_ready_o, .cycle_ready_o,
      .bus_timeout_n_o);
   cpu_core_model core (.clk_i(clk_sys_i), .ready_i(cycle_ready_o), .ad_o(addr_data_i),
      .hi_o(addr_hi_i), .st_o(proc_status_bits_i), .ale_o(addr_latch_strobe_i));
   initial
   begin
      clk_sys_i = 1'h0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   // whole run needs about 3000 cycles
   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // active selects, then local and sync ready, packed as sel_seen
   function automatic logic [30:0] exp_sel(input logic [19:0] a, input status_t st);
      logic mem, io, ia, boot;
      logic [3:0] mid, d2, dma;
      logic [6:0] per;
      logic [7:0] d16;
      mem = st inside {`STAT_FETCH, `STAT_MEM_RD, `STAT_MEM_WR};
      io = st inside {`STAT_IO_RD, `STAT_IO_WR};
      ia = (st == `STAT_INTA);
      boot = mem && a >= 20'hf8000;
      for (int i = 0; i < 4; i++)
      begin
         mid[i] = mem && a[19:17] == i;
         dma[i] = io && a[15:5] == 11'h004 + i;
         d2[i] = io && a[15:4] == 12'h000 && a[2:1] == i;
      end
      for (int i = 0; i < 7; i++)
         per[i] = io && a[15:7] == i;
      for (int i = 0; i < 8; i++)
         d16[i] = io && a[15:7] == 0 && a[6:4] == i;
      return {~mid, ~boot, ~per, ~d16, ~d2, ~dma, ~ia,
         mid[0] | mid[1] | per[0] | boot | dma[0] | ia, boot | ia};
   endfunction
   // mode 0 holds ready off then gives it, 1 keeps it off, 2 keeps it on
   task automatic run(input logic [19:0] a, input status_t st, input int w, input int mode);
      int n;
      int t0;
      @(posedge clk_sys_i);
      #1;
      async_ready_i = (mode == 2);
      fork
         core.bus_cycle(a, st);
         begin
            repeat (6) @(posedge clk_sys_i);
            #2;
            `CHK("idle sel", {29{1'h1}}, sel_seen[30:2])
            `CHK("idle den", 1'h1, data_buf_en_n_o)
            `WAIT_UNTIL(data_buf_en_n_o === 1'h0)
            t0 = cyc;
            `CHK("dir", st inside {`STAT_IO_WR, `STAT_MEM_WR}, data_dir_tx_rx_o)
            `CHK("addr", a, latched_addr_o)
            `CHK("status", st, latched_status_o)
            `CHK("sel", exp_sel(a, st), sel_seen)
            if (mode == 0)
            begin
               repeat (40) @(posedge clk_sys_i);
               #1;
               async_ready_i = 1'h1;
               `CHK("held", 1'h0, cycle_ready_o)
               t0 = cyc;
               w = 0;
            end
            `WAIT_UNTIL(cycle_ready_o === 1'h1)
            if (mode != 2)
               `CHK("waits", 1'h1, cyc - t0 >= w * 25 - 1 && cyc - t0 <= w * 25 + 4)
         end
      join
      #2;
      `CHK("end", {30{1'h1}}, {sel_seen[30:2], data_buf_en_n_o})
   endtask
   task automatic t_mem();
      run(20'h00000, `STAT_MEM_RD, 0, 0);
      run(20'h3fffe, `STAT_MEM_WR, 0, 0);
      run(20'h5a5a4, `STAT_FETCH, 0, 0);
      run(20'h7ffff, `STAT_MEM_RD, 0, 0);
      run(20'hf7fff, `STAT_MEM_WR, 0, 0);
      run(20'hf8000, `STAT_MEM_RD, 3, 1);
      run(20'hfffff, `STAT_FETCH, 3, 1);
      $display("test mem done");
   endtask
   task automatic t_io();
      for (int i = 0; i < 7; i++)
         run(20'(i * 128 + i * 9), i[0] ? `STAT_IO_WR : `STAT_IO_RD, 2, 1);
      for (int i = 0; i < 8; i++)
         run(20'(i * 16 + 15 - i), `STAT_IO_WR, 2, 1);
      for (int i = 0; i < 8; i++)
         run(20'(i * 2 + i[0]), `STAT_IO_RD, 2, 1);
      for (int i = 0; i < 4; i++)
         run(20'(128 + i * 32 + i * 7), `STAT_IO_RD, 2, 1);
      $display("test io done");
   endtask
   task automatic t_misc();
      run(20'h00000, `STAT_INTA, 0, 2);
      run(20'h00400, `STAT_IO_RD, 0, 2);
      @(posedge clk_sys_i);
      #1;
      hold_granted_i = 1'h1;
      fork
         core.bus_cycle(20'h20000, `STAT_MEM_RD);
         begin
            repeat (14) @(posedge clk_sys_i);
            #2;
            `CHK("hold sel", 5'h1f, {mid_mem_sel_n_o, boot_mem_sel_n_o})
         end
      join
      #1;
      hold_granted_i = 1'h0;
      $display("test misc done");
   endtask
   task automatic t_timeout();
      int n;
      int t0;
      @(posedge clk_sys_i);
      #1;
      async_ready_i = 1'h0;
      t0 = cyc;
      fork
         core.bus_cycle(20'h80000, `STAT_MEM_RD);
         begin
            repeat (150) @(posedge clk_sys_i);
            #2;
            `CHK("pre", 3'h4, {bus_timeout_n_o, local_not_external_o, cycle_ready_o})
            `WAIT_UNTIL(bus_timeout_n_o === 1'h0)
            `CHK("expiry", 4'hb, {cyc - t0 >= TO_CYC && cyc - t0 <= TO_CYC + 10,
               bus_timeout_n_o, local_not_external_o, cycle_ready_o})
         end
      join
      #2;
      `CHK("cleared", 1'h1, bus_timeout_n_o)
      $display("test timeout done");
   endtask
   initial
   begin
      arst_n_i = 1'h0;
      hold_granted_i = 1'h0;
      async_ready_i = 1'h0;
      repeat (20) @(posedge clk_sys_i);
      #1;
      arst_n_i = 1'h1;
      @(posedge clk_sys_i);
      #2;
      `CHK("reset", {30'h3fffffff, 6'h11, 20'h00000, 3'h7}, {low_mem_sel_n_o, sel_seen[30:2],
         data_dir_tx_rx_o, data_buf_en_n_o, local_not_external_o, sync_ready_o, cycle_ready_o,
         bus_timeout_n_o, latched_addr_o, latched_status_o})
      $display("test reset done");
      t_mem();
      t_io();
      t_misc();
      t_timeout();
      print_verdict();
   end
endmodule
`default_nettype wire
